// >>> cgrm_defs.svh
// cgrm_defs.svh: register offsets, field positions and reset values of the counter sequencer
// assumes inclusion by bare name from the design files
`ifndef CGRM_DEFS_SVH
`define CGRM_DEFS_SVH

// register byte offsets
`define CGRM_ADR_MODE    8'h00
`define CGRM_ADR_LOAD    8'h04
`define CGRM_ADR_HOLD    8'h08
`define CGRM_ADR_CMD     8'h0c
`define CGRM_ADR_COUNT   8'h10
`define CGRM_ADR_STATUS  8'h14

// mode register fields
`define CGRM_GATE_HI     15
`define CGRM_GATE_LO     13
`define CGRM_SEL_HI      7
`define CGRM_SEL_LO      5
`define CGRM_BIT_BCD     4
`define CGRM_BIT_UP      3
`define CGRM_MODE_RST    16'h0b00

// command register bits
`define CGRM_CMD_ARM     0
`define CGRM_CMD_DISARM  1
`define CGRM_CMD_LOAD    2

// mode-select codes of mode bits seven to five, and the no-gate code of the gating bits
`define CGRM_SEL_ALT     3'h3
`define CGRM_SEL_STROBE  3'h4
`define CGRM_SEL_RETRIG  3'h5
`define CGRM_SEL_RELSRC  3'h6
`define CGRM_GATE_NONE   3'h0

// terminal values and the Load and Hold reset values
`define CGRM_TERM_DOWN   16'h0001
`define CGRM_TERM_BCD    16'h9999
`define CGRM_TERM_BIN    16'hffff
`define CGRM_LOAD_RST    16'h0000
`define CGRM_HOLD_RST    16'h0000

`endif

// >>> cgrm_pkg.sv
// cgrm_pkg.sv: types shared by the counter sequencer modules
// assumes nothing beyond a SystemVerilog compiler
package cgrm_pkg;
  typedef enum logic [2:0] {
    CGRM_IDLE,
    CGRM_K,
    CGRM_L,
    CGRM_N,
    CGRM_O,
    CGRM_Q,
    CGRM_R,
    CGRM_S
  } cgrm_mode_t;
endpackage : cgrm_pkg

// >>> cgrm_edge_if.sv
// cgrm_edge_if.sv: synchronised pin level with its edge pulses
// assumes producer and consumer share i_sys_clk
interface cgrm_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport drv (output level, output rise, output fall);
  modport use_side (input level, input rise, input fall);
endinterface : cgrm_edge_if

// >>> cgrm_pin_sync.sv
// cgrm_pin_sync.sv: two-flop synchroniser plus edge detector for one pin
// assumes an asynchronous pin and the system clock
module cgrm_pin_sync (
  input  wire logic  i_sys_clk,
  input  wire logic  i_nrst,
  input  wire logic  i_pin,
  cgrm_edge_if.drv   edge_o
);
  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  always_comb begin
    next_meta = i_pin;
    next_sync = meta;
    next_prev = sync;
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  assign edge_o.level = sync;
  assign edge_o.rise  = sync & ~prev;
  assign edge_o.fall  = ~sync & prev;
endmodule : cgrm_pin_sync

// >>> cgrm_counter.sv
// cgrm_counter.sv: one 16-bit counter sequencer for the gated, alternating and retrigger modes
// assumes a classic Wishbone master on i_sys_clk; source and gate pins are asynchronous
`include "cgrm_defs.svh"

module cgrm_counter (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_nrst,
  input  wire logic                 i_wb_cyc,
  input  wire logic                 i_wb_stb,
  input  wire logic                 i_wb_we,
  input  wire logic [7:0]           i_wb_adr,
  input  wire logic [3:0]           i_wb_sel,
  input  wire logic [31:0]          i_wb_dat,
  output      logic                 o_wb_ack,
  output      logic [31:0]          o_wb_dat,
  input  wire logic                 i_src,
  input  wire logic                 i_gate,
  output      logic                 o_tc,
  output      logic                 o_armed,
  output      cgrm_pkg::cgrm_mode_t o_mode
);
  import cgrm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  cgrm_edge_if src_e ();
  cgrm_edge_if gate_e ();

  cgrm_pin_sync u_src_sync (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_pin     (i_src),
    .edge_o    (src_e)
  );

  cgrm_pin_sync u_gate_sync (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_pin     (i_gate),
    .edge_o    (gate_e)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers and state
  logic [15:0] mode_reg;
  logic [15:0] load_reg;
  logic [15:0] hold_reg;
  logic [15:0] count;
  logic        armed;
  logic        running;
  logic        phase;
  logic        retrig;
  logic        tc;
  logic        ack;
  logic [31:0] rdata;

  logic [15:0] next_mode_reg;
  logic [15:0] next_load_reg;
  logic [15:0] next_hold_reg;
  logic [15:0] next_count;
  logic        next_armed;
  logic        next_running;
  logic        next_phase;
  logic        next_retrig;
  logic        next_tc;
  logic        next_ack;
  logic [31:0] next_rdata;

  cgrm_mode_t  mode;
  logic [2:0]  gating;
  logic        gate_act;
  logic        gate_trig;
  logic        qualified;
  logic        at_term;
  logic [15:0] sel_reload;
  logic        req;
  logic        wr;
  logic        cmd_arm;
  logic        cmd_disarm;
  logic        cmd_load;

  ////////////////////////////////////////////////////////////////////////////
  // one count step, binary or four-digit decimal, up or down
  function automatic logic [15:0] cgrm_step(input logic [15:0] v, input logic up, input logic bcd);
    logic [15:0] r;
    logic        c;
    r = v;
    c = 1'b1;
    if (!bcd) begin
      r = up ? v + 16'h0001 : v - 16'h0001;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (c) begin
          if (up) begin
            if (r[4*i +: 4] == 4'h9) begin
              r[4*i +: 4] = 4'h0;
            end else begin
              r[4*i +: 4] = r[4*i +: 4] + 4'h1;
              c = 1'b0;
            end
          end else begin
            if (r[4*i +: 4] == 4'h0) begin
              r[4*i +: 4] = 4'h9;
            end else begin
              r[4*i +: 4] = r[4*i +: 4] - 4'h1;
              c = 1'b0;
            end
          end
        end
      end
    end
    return r;
  endfunction : cgrm_step

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  assign gating = mode_reg[`CGRM_GATE_HI:`CGRM_GATE_LO];

  always_comb begin
    mode = CGRM_IDLE;
    if (gating == `CGRM_GATE_NONE) begin
      if (mode_reg[`CGRM_SEL_HI:`CGRM_SEL_LO] == `CGRM_SEL_RELSRC) begin
        mode = CGRM_S;
      end
    end else if (gating[2]) begin
      unique case (mode_reg[`CGRM_SEL_HI:`CGRM_SEL_LO])
        `CGRM_SEL_ALT:    mode = gating[1] ? CGRM_L : CGRM_K;
        `CGRM_SEL_STROBE: mode = gating[1] ? CGRM_O : CGRM_N;
        `CGRM_SEL_RETRIG: mode = gating[1] ? CGRM_R : CGRM_Q;
        default:          mode = CGRM_IDLE;
      endcase
    end
  end

  // gate polarity: gating bit 0 set means active low
  assign gate_act  = gate_e.level ^ gating[0];
  assign gate_trig = gating[0] ? gate_e.fall : gate_e.rise;

  assign at_term = mode_reg[`CGRM_BIT_UP]
                 ? (mode_reg[`CGRM_BIT_BCD] ? count == `CGRM_TERM_BCD : count == `CGRM_TERM_BIN)
                 : count == `CGRM_TERM_DOWN;

  // in mode S gate low selects Load, high selects Hold; all other modes use Load
  assign sel_reload = (mode == CGRM_S && gate_e.level) ? hold_reg : load_reg;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  assign req        = i_wb_cyc & i_wb_stb & ~ack;
  assign wr         = req & i_wb_we;
  assign cmd_arm    = wr & i_wb_sel[0] & (i_wb_adr == `CGRM_ADR_CMD) & i_wb_dat[`CGRM_CMD_ARM];
  assign cmd_disarm = wr & i_wb_sel[0] & (i_wb_adr == `CGRM_ADR_CMD) & i_wb_dat[`CGRM_CMD_DISARM];
  assign cmd_load   = wr & i_wb_sel[0] & (i_wb_adr == `CGRM_ADR_CMD) & i_wb_dat[`CGRM_CMD_LOAD];

  ////////////////////////////////////////////////////////////////////////////
  // counting sequencer
  always_comb begin
    unique case (mode)
      CGRM_K, CGRM_N, CGRM_Q: qualified = armed & gate_act;
      // gate level not looked at once started
      // counts all source edges once started
      CGRM_L, CGRM_O, CGRM_R: qualified = armed & running;
      // gate level picks the reload value only, not the counted edges
      CGRM_S:                 qualified = armed;
      CGRM_IDLE:              qualified = 1'b0;
    endcase
  end

  always_comb begin
    next_count   = count;
    next_armed   = armed;
    next_running = running;
    next_phase   = phase;
    next_retrig  = retrig;
    next_tc      = 1'b0;
    next_hold_reg = hold_reg;
    if (wr && (i_wb_adr == `CGRM_ADR_HOLD)) begin
      if (i_wb_sel[0]) next_hold_reg[7:0]  = i_wb_dat[7:0];
      if (i_wb_sel[1]) next_hold_reg[15:8] = i_wb_dat[15:8];
    end
    if (src_e.rise && qualified) begin
      if (retrig) begin
        // first qualified edge after retrigger loads Load
        next_count  = load_reg;
        next_retrig = 1'b0;
      end else if (at_term) begin
        next_tc = 1'b1;
        unique case (mode)
          CGRM_K: begin
            next_count = phase ? load_reg : hold_reg;
            next_phase = ~phase;
          end
          // Hold first, Load second, then halt
          CGRM_L: begin
            next_count = phase ? load_reg : hold_reg;
            next_phase = ~phase;
            if (phase) next_running = 1'b0;
          end
          CGRM_N, CGRM_O: begin
            next_count   = load_reg;
            next_armed   = 1'b0;
            next_running = 1'b0;
          end
          CGRM_Q: next_count = load_reg;
          CGRM_R: begin
            next_count   = load_reg;
            next_running = 1'b0;
          end
          CGRM_S: begin
            next_count = sel_reload;
            next_phase = ~phase;
            if (phase) next_armed = 1'b0;
          end
          CGRM_IDLE: next_count = load_reg;
        endcase
      end else begin
        next_count = cgrm_step(count, mode_reg[`CGRM_BIT_UP], mode_reg[`CGRM_BIT_BCD]);
      end
    end
    // gate edges; the save into Hold wins over a software write
    if (gate_trig) begin
      unique case (mode)
        // start only when armed and stopped
        CGRM_L: if (armed && !running) begin
          next_running = 1'b1;
          next_phase   = 1'b0;
        end
        CGRM_N: if (armed) begin
          next_hold_reg = count;
          next_retrig   = 1'b1;
        end
        // start and retrigger on every edge while armed
        // start and retrigger on every edge while armed
        CGRM_O, CGRM_R: if (armed) begin
          next_running  = 1'b1;
          next_hold_reg = count;
          next_retrig   = 1'b1;
        end
        CGRM_Q: begin
          next_hold_reg = count;
          next_retrig   = 1'b1;
        end
        CGRM_K, CGRM_S, CGRM_IDLE: next_retrig = retrig;
      endcase
    end
    if (cmd_load) begin
      next_count  = sel_reload;
      next_retrig = 1'b0;
    end
    if (cmd_disarm) begin
      next_armed   = 1'b0;
      next_running = 1'b0;
      next_retrig  = 1'b0;
    end else if (cmd_arm) begin
      // phase restarts with Hold after arm
      next_armed = 1'b1;
      next_phase = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      count    <= 16'h0000;
      armed    <= 1'b0;
      running  <= 1'b0;
      phase    <= 1'b0;
      retrig   <= 1'b0;
      tc       <= 1'b0;
      hold_reg <= `CGRM_HOLD_RST;
    end else begin
      count    <= next_count;
      armed    <= next_armed;
      running  <= next_running;
      phase    <= next_phase;
      retrig   <= next_retrig;
      tc       <= next_tc;
      hold_reg <= next_hold_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after the request is seen
  always_comb begin
    next_mode_reg = mode_reg;
    next_load_reg = load_reg;
    next_ack      = req;
    next_rdata    = 32'h0000_0000;
    if (wr && (i_wb_adr == `CGRM_ADR_MODE)) begin
      if (i_wb_sel[0]) next_mode_reg[7:0]  = i_wb_dat[7:0];
      if (i_wb_sel[1]) next_mode_reg[15:8] = i_wb_dat[15:8];
    end
    if (wr && (i_wb_adr == `CGRM_ADR_LOAD)) begin
      if (i_wb_sel[0]) next_load_reg[7:0]  = i_wb_dat[7:0];
      if (i_wb_sel[1]) next_load_reg[15:8] = i_wb_dat[15:8];
    end
    if (req && !i_wb_we) begin
      unique case (i_wb_adr)
        `CGRM_ADR_MODE:   next_rdata = {16'h0000, mode_reg};
        `CGRM_ADR_LOAD:   next_rdata = {16'h0000, load_reg};
        `CGRM_ADR_HOLD:   next_rdata = {16'h0000, hold_reg};
        `CGRM_ADR_COUNT:  next_rdata = {16'h0000, count};
        `CGRM_ADR_STATUS: next_rdata = {27'h0000000, gate_e.level, retrig, phase, running, armed};
        default:          next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_reg <= `CGRM_MODE_RST;
      load_reg <= `CGRM_LOAD_RST;
      ack      <= 1'b0;
      rdata    <= 32'h0000_0000;
    end else begin
      mode_reg <= next_mode_reg;
      load_reg <= next_load_reg;
      ack      <= next_ack;
      rdata    <= next_rdata;
    end
  end

  assign o_wb_ack = ack;
  assign o_wb_dat = rdata;
  assign o_tc     = tc;
  assign o_armed  = armed;
  assign o_mode   = mode;
endmodule : cgrm_counter

// >>> cgrm_asserts.sv
// cgrm_asserts.sv: port-level checks of the counter sequencer
// assumes binding into cgrm_counter, whose port names it shares
`include "cgrm_defs.svh"
module cgrm_asserts (
  input wire logic                 i_sys_clk,
  input wire logic                 i_nrst,
  input wire logic                 i_wb_cyc,
  input wire logic                 i_wb_stb,
  input wire logic                 i_wb_we,
  input wire logic [7:0]           i_wb_adr,
  input wire logic [3:0]           i_wb_sel,
  input wire logic [31:0]          i_wb_dat,
  input wire logic                 o_wb_ack,
  input wire logic [31:0]          o_wb_dat,
  input wire logic                 i_src,
  input wire logic                 i_gate,
  input wire logic                 o_tc,
  input wire logic                 o_armed,
  input wire cgrm_pkg::cgrm_mode_t o_mode
);
  import cgrm_pkg::*;
  logic take;
  logic wr_cmd;
  assign take = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr_cmd = take && i_wb_we && i_wb_adr == `CGRM_ADR_CMD && i_wb_sel[0];
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  ////////////////////////////////////////////////////////////
  ack_one_cycle_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  ack_latency_a: assert property (take |=> o_wb_ack)
    else $error("request not answered next cycle");
  dat_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data outside ack");
  tc_pulse_a: assert property (o_tc |=> !o_tc)
    else $error("terminal count longer than one cycle");
  idle_no_tc_a: assert property (o_mode == CGRM_IDLE && $past(o_mode) == CGRM_IDLE |-> !o_tc)
    else $error("terminal count in idle mode");
  disarm_cmd_a: assert property (wr_cmd && i_wb_dat[`CGRM_CMD_DISARM] |=> !o_armed)
    else $error("disarm command ignored");
  arm_cause_a: assert property ($rose(o_armed) |-> $past(wr_cmd))
    else $error("armed without command");
  self_disarm_a: assert property ($fell(o_armed) |-> o_tc || $past(o_tc) || $past(wr_cmd))
    else $error("disarmed without cause");
  mode_s_a: assert property (take && i_wb_we && i_wb_adr == `CGRM_ADR_MODE && i_wb_sel[1:0] == 2'h3
    && i_wb_dat[15:0] == 16'h00c0 |=> o_mode == CGRM_S)
    else $error("mode S not decoded");
  k_armed_a: assert property (o_mode == CGRM_K && o_tc |-> o_armed)
    else $error("mode K disarmed at terminal count");
  cover property (o_tc && o_mode == CGRM_K);
  cover property (o_tc && o_mode == CGRM_N);
  cover property (o_tc && o_mode == CGRM_L);
  cover property ($fell(o_armed) && o_mode == CGRM_S);
endmodule : cgrm_asserts

bind cgrm_counter cgrm_asserts u_chk (.i_sys_clk, .i_nrst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
  .i_wb_sel, .i_wb_dat, .o_wb_ack, .o_wb_dat, .i_src, .i_gate, .o_tc, .o_armed, .o_mode);

// >>> cgrm_pin_model.sv
// cgrm_pin_model.sv: source and gate pins of the outside world
// assumes fire requests from the bench on the system clock
module cgrm_pin_model (
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  input  wire logic i_fire,
  input  wire logic i_gate_lvl,
  output      logic o_src,
  output      logic o_gate
);
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  // one source pulse: three clocks high, three low
  always_comb begin
    next_cnt = (cnt != 3'h0) ? cnt - 3'h1 : (i_fire ? 3'h6 : 3'h0);
  end
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= 3'h0;
      o_gate <= 1'b0;
    end else begin
      cnt <= next_cnt;
      o_gate <= i_gate_lvl;
    end
  end
  assign o_src = cnt > 3'h3;
endmodule : cgrm_pin_model

// >>> counter_gated_reload_modes_k_to_s_tb_top.sv
// counter_gated_reload_modes_k_to_s_tb_top.sv: bus-driven tests of the counter sequencer
// assumes cgrm_counter, cgrm_pin_model and the bound checker are compiled
`include "cgrm_defs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module counter_gated_reload_modes_k_to_s_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cgrm_pkg::*;
  logic        i_sys_clk, i_nrst, i_wb_cyc, i_wb_stb, i_wb_we, fire, gate_lvl;
  logic [7:0]  i_wb_adr;
  logic [3:0]  i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat;
  logic        o_wb_ack, i_src, i_gate, o_tc, o_armed;
  cgrm_mode_t  o_mode;
  int          n_mismatch, n_compared;
  logic [31:0] q;
  logic [3:0]  lanes = 4'h3;
  int          n_tc = 0;
  int          t;
  cgrm_counter dut (.i_sys_clk, .i_nrst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
    .i_wb_dat, .o_wb_ack, .o_wb_dat, .i_src, .i_gate, .o_tc, .o_armed, .o_mode);
  cgrm_pin_model u_pins (.i_sys_clk, .i_nrst, .i_fire(fire), .i_gate_lvl(gate_lvl),
    .o_src(i_src), .o_gate(i_gate));
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  // counts terminal-count pulses; o_tc stands one cycle
  always @(posedge i_sys_clk) begin
    if (o_tc === 1'b1) n_tc <= n_tc + 1;
  end
  ////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int k;
    k = 0;
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_sel <= lanes;
    i_wb_adr <= a;
    i_wb_dat <= {16'h0, d};
    do begin
      @(posedge i_sys_clk);
      k++;
    end while (o_wb_ack !== 1'b1 && k < 20);
    if (o_wb_ack !== 1'b1) begin
      n_mismatch++;
      end_of_test;
    end
    q = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    @(posedge i_sys_clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0);
    `CHK(q, {16'h0000, e})
  endtask : rc
  task automatic pulse(input int n);
    repeat (n) begin
      fire <= 1'b1;
      @(posedge i_sys_clk);
      fire <= 1'b0;
      repeat (8) @(posedge i_sys_clk);
    end
  endtask : pulse
  task automatic gt(input logic v);
    gate_lvl <= v;
    repeat (6) @(posedge i_sys_clk);
  endtask : gt
  ////////////////////////////////////////////////////////////
  initial begin
    {i_nrst, i_wb_cyc, i_wb_stb, i_wb_we, fire, gate_lvl} = 6'h0;
    i_wb_adr = 8'h00;
    i_wb_sel = 4'h3;
    i_wb_dat = 32'h0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (8) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    @(posedge i_sys_clk);
    rc(`CGRM_ADR_MODE, 16'h0b00);
    rc(`CGRM_ADR_HOLD, 16'h0000);
    rc(8'h20, 16'h0000);
    // level-gated alternating reload
    wr(`CGRM_ADR_MODE, 16'h8060);
    wr(`CGRM_ADR_LOAD, 16'h0002);
    wr(`CGRM_ADR_HOLD, 16'h0003);
    wr(`CGRM_ADR_CMD, 16'h0004);
    wr(`CGRM_ADR_CMD, 16'h0001);
    pulse(1);
    rc(`CGRM_ADR_COUNT, 16'h0002);
    gt(1'b1);
    pulse(1);
    rc(`CGRM_ADR_COUNT, 16'h0001);
    pulse(1);
    rc(`CGRM_ADR_COUNT, 16'h0003);
    pulse(3);
    rc(`CGRM_ADR_COUNT, 16'h0002);
    `CHK(o_armed, 1'b1)
    // level-gated strobe with retrigger
    gt(1'b0);
    wr(`CGRM_ADR_CMD, 16'h0002);
    wr(`CGRM_ADR_MODE, 16'h8080);
    wr(`CGRM_ADR_LOAD, 16'h0006);
    wr(`CGRM_ADR_CMD, 16'h0004);
    gt(1'b1);
    wr(`CGRM_ADR_CMD, 16'h0001);
    pulse(2);
    gt(1'b0);
    gt(1'b1);
    rc(`CGRM_ADR_HOLD, 16'h0004);
    pulse(1);
    rc(`CGRM_ADR_COUNT, 16'h0006);
    pulse(1);
    rc(`CGRM_ADR_COUNT, 16'h0005);
    pulse(5);
    rc(`CGRM_ADR_COUNT, 16'h0006);
    `CHK(o_armed, 1'b0)
    // gate-selected reload source
    wr(`CGRM_ADR_MODE, 16'h00c0);
    `CHK(o_mode, CGRM_S)
    wr(`CGRM_ADR_LOAD, 16'h0002);
    wr(`CGRM_ADR_HOLD, 16'h0007);
    wr(`CGRM_ADR_CMD, 16'h0004);
    rc(`CGRM_ADR_COUNT, 16'h0007);
    gt(1'b0);
    wr(`CGRM_ADR_CMD, 16'h0001);
    pulse(7);
    rc(`CGRM_ADR_COUNT, 16'h0002);
    `CHK(o_armed, 1'b1)
    pulse(2);
    `CHK(o_armed, 1'b0)
    // edge-started strobe with retrigger
    wr(`CGRM_ADR_MODE, 16'hc080);
    wr(`CGRM_ADR_LOAD, 16'h0005);
    wr(`CGRM_ADR_CMD, 16'h0004);
    wr(`CGRM_ADR_LOAD, 16'h0003);
    // edge before arm must not start counting
    gt(1'b1);
    gt(1'b0);
    wr(`CGRM_ADR_CMD, 16'h0001);
    pulse(1);
    rc(`CGRM_ADR_COUNT, 16'h0005);
    gt(1'b1);
    rc(`CGRM_ADR_HOLD, 16'h0005);
    pulse(1);
    rc(`CGRM_ADR_COUNT, 16'h0003);
    pulse(1);
    rc(`CGRM_ADR_COUNT, 16'h0002);
    pulse(2);
    rc(`CGRM_ADR_COUNT, 16'h0003);
    `CHK(o_armed, 1'b0)
    // edge-started alternating reload
    wr(`CGRM_ADR_MODE, 16'hc060);
    wr(`CGRM_ADR_LOAD, 16'h0002);
    wr(`CGRM_ADR_HOLD, 16'h0003);
    wr(`CGRM_ADR_CMD, 16'h0004);
    gt(1'b0);
    gt(1'b1);
    gt(1'b0);
    wr(`CGRM_ADR_CMD, 16'h0001);
    pulse(1);
    rc(`CGRM_ADR_COUNT, 16'h0002);
    gt(1'b1);
    pulse(1);
    rc(`CGRM_ADR_COUNT, 16'h0001);
    pulse(1);
    rc(`CGRM_ADR_COUNT, 16'h0003);
    // a second gate edge while running must not restart the phase
    gt(1'b0);
    gt(1'b1);
    pulse(3);
    rc(`CGRM_ADR_COUNT, 16'h0002);
    pulse(1);
    rc(`CGRM_ADR_COUNT, 16'h0002);
    rc(`CGRM_ADR_STATUS, 16'h0011);
    // level-gated repeating count with retrigger, disarmed save
    wr(`CGRM_ADR_CMD, 16'h0002);
    wr(`CGRM_ADR_MODE, 16'h80a0);
    wr(`CGRM_ADR_LOAD, 16'h0004);
    wr(`CGRM_ADR_CMD, 16'h0004);
    wr(`CGRM_ADR_LOAD, 16'h0003);
    gt(1'b0);
    gt(1'b1);
    rc(`CGRM_ADR_HOLD, 16'h0004);
    rc(`CGRM_ADR_STATUS, 16'h0018);
    wr(`CGRM_ADR_CMD, 16'h0001);
    pulse(1);
    rc(`CGRM_ADR_COUNT, 16'h0003);
    pulse(1);
    rc(`CGRM_ADR_COUNT, 16'h0002);
    pulse(2);
    rc(`CGRM_ADR_COUNT, 16'h0003);
    `CHK(o_armed, 1'b1)
    gt(1'b0);
    pulse(1);
    rc(`CGRM_ADR_COUNT, 16'h0003);
    // edge-started one-shot with retrigger
    wr(`CGRM_ADR_CMD, 16'h0002);
    wr(`CGRM_ADR_MODE, 16'hc0a0);
    wr(`CGRM_ADR_LOAD, 16'h0002);
    wr(`CGRM_ADR_CMD, 16'h0004);
    wr(`CGRM_ADR_LOAD, 16'h0004);
    wr(`CGRM_ADR_CMD, 16'h0001);
    pulse(1);
    rc(`CGRM_ADR_COUNT, 16'h0002);
    gt(1'b1);
    pulse(1);
    rc(`CGRM_ADR_COUNT, 16'h0004);
    pulse(1);
    rc(`CGRM_ADR_COUNT, 16'h0003);
    gt(1'b0);
    gt(1'b1);
    rc(`CGRM_ADR_HOLD, 16'h0003);
    pulse(5);
    rc(`CGRM_ADR_COUNT, 16'h0004);
    `CHK(o_armed, 1'b1)
    pulse(1);
    rc(`CGRM_ADR_COUNT, 16'h0004);
    // byte lane 0 only
    wr(`CGRM_ADR_CMD, 16'h0002);
    gt(1'b0);
    lanes = 4'h1;
    wr(`CGRM_ADR_LOAD, 16'habcd);
    lanes = 4'h3;
    rc(`CGRM_ADR_LOAD, 16'h00cd);
    // decimal up counting with gate-low reload
    wr(`CGRM_ADR_MODE, 16'h00d8);
    wr(`CGRM_ADR_LOAD, 16'h9989);
    wr(`CGRM_ADR_CMD, 16'h0004);
    rc(`CGRM_ADR_COUNT, 16'h9989);
    wr(`CGRM_ADR_CMD, 16'h0001);
    pulse(1);
    rc(`CGRM_ADR_COUNT, 16'h9990);
    pulse(9);
    rc(`CGRM_ADR_COUNT, 16'h9999);
    pulse(1);
    rc(`CGRM_ADR_COUNT, 16'h9989);
    // binary up counting to the top value
    wr(`CGRM_ADR_CMD, 16'h0002);
    wr(`CGRM_ADR_MODE, 16'h00c8);
    wr(`CGRM_ADR_LOAD, 16'hfffe);
    wr(`CGRM_ADR_CMD, 16'h0004);
    wr(`CGRM_ADR_CMD, 16'h0001);
    t = n_tc;
    pulse(1);
    `CHK(n_tc, t)
    pulse(1);
    `CHK(n_tc, t + 1)
    rc(`CGRM_ADR_COUNT, 16'hfffe);
    end_of_test;
  end
endmodule : counter_gated_reload_modes_k_to_s_tb_top
